// >>> hw/hba_pkg.sv
package hba_pkg;
    // ----------------------------------------
    // bus cycle and arbitration constants
    // ----------------------------------------
    localparam int HBA_SLAVE_WAITS = 2;
    localparam int HBA_ADDR_W = 32;
    localparam int HBA_DATA_W = 32;
    localparam logic [15:0] HBA_CS_MATCH = 16'h5800;
    localparam int HBA_MODE_BIT = 4;
    localparam int HBA_IRQ_SRC = 8;
    localparam int HBA_IPL_W = 3;
    // cycle types on the device's three cycle-definition lines
    localparam logic [2:0] HBA_CYC_INTA = 3'h0;
    localparam logic [2:0] HBA_CYC_HALT = 3'h1;
    localparam logic [2:0] HBA_CYC_IORD = 3'h2;
    localparam logic [2:0] HBA_CYC_IOWR = 3'h3;
    localparam logic [2:0] HBA_CYC_CODE = 3'h4;
    localparam logic [2:0] HBA_CYC_MRD = 3'h6;
    localparam logic [2:0] HBA_CYC_MWR = 3'h7;
    // master sequencer states
    typedef enum logic [1:0] {
        HBA_IDLE = 2'h0,
        HBA_REQ = 2'h1,
        HBA_ADDR = 2'h2,
        HBA_DATA = 2'h3
    } hba_mst_e;
    typedef enum logic [1:0] {
        HBA_S_IDLE = 2'h0,
        HBA_S_WAIT = 2'h1,
        HBA_S_RDY = 2'h2,
        HBA_S_END = 2'h3
    } hba_slv_e;
endpackage : hba_pkg

// >>> hw/hba_link_if.sv
interface hba_link_if;
    // ----------------------------------------
    // arbitration
    // ----------------------------------------
    logic hold_req;
    logic grant_in;
    // ----------------------------------------
    // shared bus; address and data drivers with their enables, lanes, strobe and write follow the address enable
    // ----------------------------------------
    logic [31:0] addr_dev;
    logic [31:0] addr_gl;
    logic addr_dev_oe;
    logic addr_gl_oe;
    logic [31:0] data_dev;
    logic [31:0] data_gl;
    logic data_dev_oe;
    logic data_gl_oe;
    logic [3:0] byte_lane_en_n_dev;
    logic [3:0] byte_lane_en_n_gl;
    logic addr_strobe_n_dev;
    logic addr_strobe_n_gl;
    logic data_code_n;
    logic memory_or_io_n;
    logic write_dev;
    logic write_gl;
    logic chip_select_n;
    logic ready_in;
    logic ready_out;
    logic dev_irq;
    // resolved views
    wire [31:0] addr = addr_dev_oe ? addr_dev : addr_gl;
    wire [31:0] data = data_dev_oe ? data_dev : (data_gl_oe ? data_gl : '1);
    wire [3:0] byte_lane_en_n = addr_dev_oe ? byte_lane_en_n_dev : byte_lane_en_n_gl;
    wire addr_strobe_n = addr_dev_oe ? addr_strobe_n_dev : addr_strobe_n_gl;
    wire write = addr_dev_oe ? write_dev : write_gl;
    modport dev (
        output hold_req, addr_dev, addr_dev_oe, data_dev, data_dev_oe,
        output byte_lane_en_n_dev, addr_strobe_n_dev, data_code_n, memory_or_io_n,
        output write_dev, ready_out, dev_irq,
        input grant_in, addr, data, byte_lane_en_n, addr_strobe_n, write,
        input chip_select_n, ready_in
    );
    modport glue (
        output grant_in, addr_gl, addr_gl_oe, data_gl, data_gl_oe,
        output byte_lane_en_n_gl, addr_strobe_n_gl, write_gl, chip_select_n, ready_in,
        input hold_req, addr, data, byte_lane_en_n, addr_strobe_n, write,
        input data_code_n, memory_or_io_n, ready_out, dev_irq, addr_dev_oe
    );
endinterface : hba_link_if

// >>> hw/hba_device.sv
// Operation
// RULE1: host sets sixteen-bit mode bit first
// RULE2: glue maps three cycle lines to four
// RULE3: processor status bypasses conversion when master
// RULE4: glue derives device write from status
// RULE5: never two drivers on shared bus
// RULE6: chip select at upper half 5800
// RULE7: slave: size and address to lanes
// RULE8: master: lanes to size, grant selects
// RULE9: swap byte order both directions
// RULE10: build processor strobes from device strobes
// RULE11: asynchronous termination via size acks only
// RULE12: translate request, grant and acknowledge lines
// RULE13: eight-input priority encoder to level
// RULE14: device requests hold, slave on access
// RULE15: processor finishes instruction, then grants
// RULE16: no driving before grant seen
// RULE17: last in chain: downstream request low
// RULE18: cycle is address then data state
// RULE19: ready false repeats data state
// RULE20: master outputs stable through data state
// RULE21: master waits in data state for ready
// RULE22: slave fixed waits, drives ready, samples ready
// RULE23: grant inactive, transceivers off in reset
module hba_device
    import hba_pkg::*;
#(
    parameter int SLAVE_WAITS = HBA_SLAVE_WAITS
) (
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // link to glue
    hba_link_if.dev bus,
    // user side: master request
    input wire logic mst_req,
    input wire logic mst_write,
    input wire logic mst_code,
    input wire logic mst_mem,
    input wire logic [31:0] mst_addr,
    input wire logic [3:0] mst_lanes_n,
    input wire logic [31:0] mst_wdata,
    output logic mst_ack,
    output logic [31:0] mst_rdata,
    output logic mst_busy,
    // user side: register window
    output logic reg_wr,
    output logic [7:0] reg_idx,
    output logic [31:0] reg_wdata,
    output logic [3:0] reg_lanes_n,
    input wire logic [31:0] reg_rdata,
    input wire logic irq
);
    if (SLAVE_WAITS < 0 || SLAVE_WAITS > 15) begin : g_bad_waits
        $error("bad SLAVE_WAITS");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        hba_mst_e mst;
        hba_slv_e slv;
        logic [3:0] wcnt;
        logic hold;
        logic drive;
        logic ads_n;
        logic [31:0] addr;
        logic [3:0] lanes_n;
        logic [31:0] wdata;
        logic wr;
        logic dc;
        logic mio;
        logic ack;
        logic [31:0] rdata;
        logic rdy;
        logic rwr;
        logic [7:0] ridx;
        logic [31:0] rwd;
        logic [3:0] rlanes;
        logic [31:0] rout;
        logic rout_oe;
        logic [1:0] gsync;
        logic [1:0] rsync;
        logic [1:0] csync;
    } hba_dev_s;

    hba_dev_s r;
    hba_dev_s next_r;
    logic grant_s;
    logic ready_s;
    logic cs_s;

    // grant, ready and chip select from the far side pass two flops before use
    assign grant_s = r.gsync[1];
    assign ready_s = r.rsync[1];
    assign cs_s = r.csync[1];

    always_comb begin
        next_r = r;
        next_r.gsync = {r.gsync[0], bus.grant_in};
        next_r.rsync = {r.rsync[0], bus.ready_in};
        next_r.csync = {r.csync[0], bus.chip_select_n};
        next_r.ack = 1'b0;
        next_r.rwr = 1'b0;
        // ----------------------------------------
        // master sequencer
        // ----------------------------------------
        unique case (r.mst)
            HBA_IDLE: begin
                if (mst_req && r.slv == HBA_S_IDLE) begin
                    next_r.hold = 1'b1; // see RULE14
                    next_r.addr = mst_addr;
                    next_r.lanes_n = mst_lanes_n;
                    next_r.wdata = mst_wdata;
                    next_r.wr = mst_write;
                    next_r.dc = mst_code;
                    next_r.mio = mst_mem;
                    next_r.mst = HBA_REQ;
                end
            end
            HBA_REQ: begin
                // nothing driven until grant seen, see RULE16
                if (grant_s) begin
                    next_r.drive = 1'b1;
                    next_r.ads_n = 1'b0;
                    next_r.mst = HBA_ADDR; // see RULE18
                end
            end
            HBA_ADDR: begin
                next_r.ads_n = 1'b1;
                next_r.mst = HBA_DATA;
            end
            HBA_DATA: begin
                // outputs frozen here until ready, see RULE19 RULE20 RULE21
                if (ready_s) begin
                    next_r.ack = 1'b1;
                    next_r.rdata = bus.data;
                    next_r.hold = 1'b0;
                    next_r.drive = 1'b0;
                    next_r.mst = HBA_IDLE;
                end
            end
        endcase
        // ----------------------------------------
        // slave responder, fixed wait count
        // ----------------------------------------
        unique case (r.slv)
            HBA_S_IDLE: begin
                if (!cs_s && !r.drive && r.mst != HBA_REQ) begin
                    next_r.wcnt = 4'(SLAVE_WAITS);
                    next_r.ridx = bus.addr[9:2];
                    next_r.rlanes = bus.byte_lane_en_n;
                    next_r.slv = HBA_S_WAIT;
                end
            end
            HBA_S_WAIT: begin
                if (r.wcnt == 4'h0) begin
                    next_r.rdy = 1'b1; // see RULE22
                    next_r.rwd = bus.data;
                    next_r.rwr = bus.write;
                    next_r.rout = reg_rdata;
                    next_r.rout_oe = !bus.write;
                    next_r.slv = HBA_S_RDY;
                end else begin
                    next_r.wcnt = r.wcnt - 4'h1;
                end
            end
            HBA_S_RDY: begin
                // end of cycle is learned from the shared ready line
                if (ready_s) begin
                    next_r.rdy = 1'b0;
                    next_r.rout_oe = 1'b0;
                    next_r.slv = HBA_S_END; // see RULE22
                end
            end
            HBA_S_END: begin
                if (cs_s) next_r.slv = HBA_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.mst <= HBA_IDLE;
            r.slv <= HBA_S_IDLE;
            r.ads_n <= 1'b1;
            r.gsync <= 2'h0;
            r.rsync <= 2'h0;
            r.csync <= 2'h3;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign bus.hold_req = r.hold;
    assign bus.addr_dev = r.addr;
    assign bus.addr_dev_oe = r.drive; // see RULE16
    assign bus.data_dev = r.drive ? r.wdata : r.rout;
    assign bus.data_dev_oe = (r.drive && r.wr) || r.rout_oe;
    assign bus.byte_lane_en_n_dev = r.lanes_n;
    assign bus.addr_strobe_n_dev = r.ads_n;
    assign bus.data_code_n = r.dc;
    assign bus.memory_or_io_n = r.mio;
    assign bus.write_dev = r.wr;
    assign bus.ready_out = r.rdy;
    assign bus.dev_irq = irq;
    assign mst_ack = r.ack;
    assign mst_rdata = r.rdata;
    assign mst_busy = r.mst != HBA_IDLE;
    assign reg_wr = r.rwr;
    assign reg_idx = r.ridx;
    assign reg_wdata = r.rwd;
    assign reg_lanes_n = r.rlanes;
endmodule : hba_device

// >>> hw/hba_glue.sv
module hba_glue
    import hba_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // link to device
    hba_link_if.glue bus,
    // processor arbitration
    input wire logic bus_request_n,
    output logic bus_grant_n,
    input wire logic bus_grant_ack_n,
    input wire logic downstream_hold_req,
    // processor bus
    input wire logic [31:0] cpu_addr,
    input wire logic [31:0] cpu_wdata,
    input wire logic cpu_addr_strobe_n,
    input wire logic cpu_rw,
    input wire logic xfer_size0,
    input wire logic xfer_size1,
    output logic [31:0] cpu_rdata,
    output logic cpu_addr_strobe_out_n,
    output logic cpu_data_strobe_n,
    output logic data_buffer_en_n,
    output logic early_cycle_start_n,
    output logic cpu_rw_out,
    output logic [1:0] cpu_size_out,
    output logic [1:0] cpu_a_out,
    input wire logic size_ack0_n,
    input wire logic size_ack1_n,
    output logic size_ack_out0_n,
    output logic size_ack_out1_n,
    // sixteen-bit status encoding
    output logic cpu_status0_n,
    output logic cpu_status1_n,
    output logic cpu_code_or_ack_n,
    output logic cpu_mio,
    // interrupts
    input wire logic [6:0] ext_irq,
    output logic [2:0] cpu_ipl
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic grant;
        logic [1:0] ack_sync;
        logic [1:0] req_sync;
        logic [1:0] bus_grant_ack_n_sync;
    } hba_glue_s;

    hba_glue_s r;
    hba_glue_s next_r;
    logic dev_master;
    logic cs_hit;

    // big/little endian lane swap, see RULE9
    function automatic logic [31:0] hba_swap(input logic [31:0] d);
        hba_swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction : hba_swap

    always_comb begin
        next_r = r;
        next_r.ack_sync = {r.ack_sync[0], !(size_ack0_n && size_ack1_n)};
        next_r.req_sync = {r.req_sync[0], !bus_request_n};
        next_r.bus_grant_ack_n_sync = {r.bus_grant_ack_n_sync[0], !bus_grant_ack_n};
        // grant to device only when processor released the bus
        // a foreign owner keeps the bus until it lets go of its acknowledge
        if (bus.hold_req && !downstream_hold_req && !r.req_sync[1] && !r.bus_grant_ack_n_sync[1]) begin
            next_r.grant = 1'b1; // see RULE12 RULE15 RULE17
        end else if (!bus.hold_req) begin
            next_r.grant = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0; // see RULE23
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign dev_master = r.grant;
    assign bus.grant_in = r.grant;
    assign bus_grant_n = !(bus.hold_req && r.grant); // see RULE12
    assign cs_hit = cpu_addr[31:16] == HBA_CS_MATCH;
    assign bus.chip_select_n = !(cs_hit && !cpu_addr_strobe_n && !dev_master); // see RULE6
    // address transceiver: processor side only when it owns the bus, see RULE5
    assign bus.addr_gl = cpu_addr;
    assign bus.addr_gl_oe = !dev_master && !rst;
    assign bus.data_gl = hba_swap(cpu_wdata);
    // device reads as master take their data through the processor-side transceiver
    assign bus.data_gl_oe = !rst && (dev_master ? bus.addr_dev_oe && !bus.write
        : !cpu_rw); // see RULE5 RULE23
    assign bus.write_gl = !cpu_rw; // see RULE4
    assign bus.addr_strobe_n_gl = cpu_addr_strobe_n;
    // size and low address to lanes, see RULE7
    always_comb begin
        logic [1:0] sz;
        sz = {xfer_size1, xfer_size0};
        unique case ({sz, cpu_addr[1:0]})
            // lanes follow the swapped data, so byte offset n lands on lane n
            4'h4: bus.byte_lane_en_n_gl = 4'he;
            4'h5: bus.byte_lane_en_n_gl = 4'hd;
            4'h6: bus.byte_lane_en_n_gl = 4'hb;
            4'h7: bus.byte_lane_en_n_gl = 4'h7;
            4'h8: bus.byte_lane_en_n_gl = 4'hc;
            4'ha: bus.byte_lane_en_n_gl = 4'h3;
            default: bus.byte_lane_en_n_gl = 4'h0;
        endcase
    end
    // lanes to size and address when device masters, see RULE8
    always_comb begin
        cpu_size_out = 2'h0;
        cpu_a_out = 2'h0;
        unique casez (bus.byte_lane_en_n)
            4'b0111: begin cpu_size_out = 2'h1; cpu_a_out = 2'h3; end
            4'b1011: begin cpu_size_out = 2'h1; cpu_a_out = 2'h2; end
            4'b1101: begin cpu_size_out = 2'h1; cpu_a_out = 2'h1; end
            4'b1110: begin cpu_size_out = 2'h1; cpu_a_out = 2'h0; end
            4'b0011: begin cpu_size_out = 2'h2; cpu_a_out = 2'h2; end
            4'b1100: begin cpu_size_out = 2'h2; cpu_a_out = 2'h0; end
            default: begin cpu_size_out = 2'h0; cpu_a_out = 2'h0; end
        endcase
    end
    assign cpu_rdata = hba_swap(bus.data); // see RULE9
    // processor strobes from device strobes, see RULE10 RULE11
    // address and data strobes wait for the device's own drive; early cycle start needs only the grant and a low strobe
    assign cpu_addr_strobe_out_n = !(dev_master && bus.hold_req && bus.addr_dev_oe);
    assign early_cycle_start_n = !(dev_master && !bus.addr_strobe_n);
    assign cpu_data_strobe_n = !(dev_master && bus.hold_req && bus.addr_dev_oe && bus.addr_strobe_n);
    assign data_buffer_en_n = cpu_data_strobe_n;
    assign cpu_rw_out = !bus.write;
    // as master only the asynchronous acks end a cycle, as slave the device's own ready comes back, see RULE11
    assign bus.ready_in = dev_master ? r.ack_sync[1] : bus.ready_out;
    assign size_ack_out0_n = !(bus.ready_out && !dev_master);
    assign size_ack_out1_n = !(bus.ready_out && !dev_master);
    // status encoding when device masters, idle levels when processor masters, see RULE2 RULE3
    always_comb begin
        cpu_status0_n = 1'b1;
        cpu_status1_n = 1'b1;
        cpu_code_or_ack_n = 1'b1;
        cpu_mio = 1'b0;
        if (dev_master) begin
            cpu_mio = bus.memory_or_io_n;
            cpu_code_or_ack_n = bus.data_code_n;
            cpu_status0_n = !bus.write;
            cpu_status1_n = bus.write;
        end
    end
    // priority encoder, device lowest of eight, see RULE13
    always_comb begin
        cpu_ipl = {2'h0, bus.dev_irq};
        for (int i = 0; i < 7; i++) begin
            if (ext_irq[i]) cpu_ipl = 3'(i + 1);
        end
    end
endmodule : hba_glue

// >>> verification/hba_link_monitor.sv
module hba_link_monitor
    import hba_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link signals
    input wire logic hold_req,
    input wire logic grant_in,
    input wire logic addr_dev_oe,
    input wire logic addr_gl_oe,
    input wire logic data_dev_oe,
    input wire logic data_gl_oe,
    input wire logic [31:0] addr,
    input wire logic [3:0] byte_lane_en_n,
    input wire logic addr_strobe_n,
    input wire logic write,
    input wire logic chip_select_n,
    input wire logic ready_in,
    input wire logic ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ------------------------
    // cycle phases
    // ------------------------
    sequence addr_state;
        addr_dev_oe && !addr_strobe_n;
    endsequence
    sequence slave_start;
        $fell(chip_select_n);
    endsequence
    // ------------------------
    // checks
    // ------------------------
    AST_ONE_DRIVER: assert property (
        !(addr_dev_oe && addr_gl_oe) && !(data_dev_oe && data_gl_oe))
        else $error("two drivers on the shared bus");
    // reset itself is the cause here, so this one is not disabled by it
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        rst [*2] |-> !grant_in && !addr_gl_oe && !data_gl_oe)
        else $error("glue active during reset");
    AST_GRANT_FIRST: assert property (
        $rose(addr_dev_oe) |-> grant_in)
        else $error("device drives bus without grant");
    AST_HOLD_KEPT: assert property (
        hold_req && !grant_in |=> hold_req)
        else $error("hold request dropped before grant");
    AST_GRANT_ON_REQ: assert property (
        $rose(grant_in) |-> hold_req)
        else $error("grant without hold request");
    AST_ADS_ONE: assert property (
        addr_state |=> addr_strobe_n)
        else $error("address state longer than one cycle");
    AST_MST_STABLE: assert property (
        addr_state |=> ($stable(addr) && $stable(byte_lane_en_n) && $stable(write))
            until ready_in)
        else $error("master outputs moved in data state");
    AST_MST_WAIT: assert property (
        addr_state |-> ##[1:60] ready_in)
        else $error("data state never ended");
    AST_CS_MATCH: assert property (
        slave_start |-> addr[31:16] == HBA_CS_MATCH)
        else $error("chip select outside its window");
    AST_SLAVE_WAIT: assert property (
        slave_start |-> !ready_out [*3] ##[1:12] ready_out)
        else $error("slave ready timing wrong");
    AST_READY_HELD: assert property (
        $rose(ready_out) |=> ready_out [*2])
        else $error("slave ready dropped early");
endmodule : hba_link_monitor

// >>> verification/host_bus_adapter_glue_bench.sv
module host_bus_adapter_glue_bench;
    import hba_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------
    // signals
    // ------------------------
    logic clk, rst, irq, mst_req, mst_write, mst_ack, reg_wr, bus_grant_ack_n;
    logic cpu_addr_strobe_n, cpu_rw, xfer_size0, xfer_size1, size_ack0_n, size_ack1_n;
    logic cpu_addr_strobe_out_n, cpu_data_strobe_n, cpu_rw_out, size_ack_out0_n;
    logic size_ack_out1_n, acked, wr_seen;
    logic bus_request_n, bus_grant_n, data_buffer_en_n, early_cycle_start_n;
    logic cpu_status0_n, cpu_status1_n, cpu_code_or_ack_n, cpu_mio;
    logic [31:0] mst_addr, mst_wdata, mst_rdata, reg_wdata, reg_rdata;
    logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, cap_data, rdv;
    logic [11:0] cap_meta;
    logic [7:0] reg_idx;
    logic [3:0] mst_lanes_n, reg_lanes_n;
    logic [1:0] cpu_size_out, cpu_a_out;
    logic [6:0] ext_irq;
    logic [2:0] cpu_ipl;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    hba_link_if lnk ();
    hba_device hba_device_i (.clk, .rst, .ce(1'b1), .bus(lnk), .mst_req, .mst_write,
        .mst_code(1'b1), .mst_mem(1'b1), .mst_addr, .mst_lanes_n, .mst_wdata, .mst_ack,
        .mst_rdata, .mst_busy(), .reg_wr, .reg_idx, .reg_wdata, .reg_lanes_n, .reg_rdata, .irq);
    hba_glue hba_glue_i (.clk, .rst, .ce(1'b1), .bus(lnk), .bus_request_n,
        .bus_grant_n, .bus_grant_ack_n, .downstream_hold_req(1'b0), .cpu_addr, .cpu_wdata,
        .cpu_addr_strobe_n, .cpu_rw, .xfer_size0, .xfer_size1, .cpu_rdata,
        .cpu_addr_strobe_out_n, .cpu_data_strobe_n, .data_buffer_en_n,
        .early_cycle_start_n, .cpu_rw_out, .cpu_size_out, .cpu_a_out, .size_ack0_n,
        .size_ack1_n, .size_ack_out0_n, .size_ack_out1_n, .cpu_status0_n, .cpu_status1_n,
        .cpu_code_or_ack_n, .cpu_mio, .ext_irq, .cpu_ipl);
    hba_link_monitor hba_link_monitor_i (.clk, .rst, .hold_req(lnk.hold_req),
        .grant_in(lnk.grant_in), .addr_dev_oe(lnk.addr_dev_oe), .addr_gl_oe(lnk.addr_gl_oe),
        .data_dev_oe(lnk.data_dev_oe), .data_gl_oe(lnk.data_gl_oe), .addr(lnk.addr),
        .byte_lane_en_n(lnk.byte_lane_en_n), .addr_strobe_n(lnk.addr_strobe_n),
        .write(lnk.write), .chip_select_n(lnk.chip_select_n), .ready_in(lnk.ready_in),
        .ready_out(lnk.ready_out));
    // ------------------------
    // helpers
    // ------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt = error_cnt + 1;
            print_verdict();
        end
    end
    // the write pulse lands in the same cycle as the processor ack, so catch it apart
    always @(posedge clk) begin
        if (reg_wr === 1'b1) begin
            wr_seen = 1'b1;
            cap_data = reg_wdata;
            cap_meta = {reg_idx, reg_lanes_n};
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic print_verdict;
        if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    function automatic logic [31:0] swap(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : swap
    // processor cycle into the device window, abandoned after 30 cycles
    task automatic cpu_cycle(input logic [31:0] a, input logic rd, input logic [1:0] sz,
        input logic [31:0] wd);
        acked = 1'b0;
        wr_seen = 1'b0;
        @(posedge clk);
        cpu_addr <= a;
        cpu_rw <= rd;
        {xfer_size1, xfer_size0} <= sz;
        cpu_wdata <= wd;
        cpu_addr_strobe_n <= 1'b0;
        for (int n = 0; n < 30 && !acked; n++) begin
            @(posedge clk);
            if (size_ack_out0_n === 1'b0 && size_ack_out1_n === 1'b0) begin
                acked = 1'b1;
                rdv = cpu_rdata;
            end
        end
        cpu_addr_strobe_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : cpu_cycle
    // device-mastered cycle; blk cycles of foreign ownership come first
    task automatic mst_cycle(input logic wr, input logic [31:0] a, input logic [3:0] ln,
        input logic [3:0] esz, input int blk);
        @(posedge clk);
        mst_req <= 1'b1;
        mst_write <= wr;
        mst_addr <= a;
        mst_lanes_n <= ln;
        mst_wdata <= 32'h11223344;
        cpu_wdata <= 32'h55667788;
        repeat (blk) begin
            @(posedge clk);
            check(32'(lnk.grant_in), 32'h0);
        end
        bus_grant_ack_n <= 1'b1;
        bus_request_n <= 1'b1;
        for (int n = 0; n < 40 && cpu_addr_strobe_out_n !== 1'b0; n++) @(posedge clk);
        mst_req <= 1'b0;
        check(lnk.addr, a);
        check(32'(early_cycle_start_n), 32'h0);
        check(32'({cpu_status0_n, cpu_status1_n, cpu_code_or_ack_n, cpu_mio}),
            wr ? 32'h7 : 32'hb);
        check(32'({cpu_rw_out, cpu_size_out, cpu_a_out}), 32'({~wr, esz}));
        repeat (6) begin
            @(posedge clk);
            check(32'({mst_ack, cpu_data_strobe_n}), 32'h0);
            check(32'({data_buffer_en_n, bus_grant_n}), 32'h0);
        end
        if (wr) check(cpu_rdata, swap(32'h11223344));
        size_ack0_n <= 1'b0;
        size_ack1_n <= 1'b0;
        for (int n = 0; n < 20 && mst_ack !== 1'b1; n++) @(posedge clk);
        check(32'(mst_ack), 32'h1);
        if (!wr) check(32'(mst_rdata[23:16]), 32'h77);
        for (int n = 0; n < 20 && cpu_addr_strobe_out_n !== 1'b1; n++) @(posedge clk);
        size_ack0_n <= 1'b1;
        size_ack1_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : mst_cycle
    // ------------------------
    // tests
    // ------------------------
    initial begin
        {rst, irq, mst_req, mst_write, cpu_rw, xfer_size0, xfer_size1} = 7'h40;
        {cpu_addr_strobe_n, size_ack0_n, size_ack1_n, bus_grant_ack_n, bus_request_n} = 5'h1f;
        {mst_addr, mst_wdata, cpu_addr, cpu_wdata} = '0;
        {mst_lanes_n, ext_irq} = '0;
        reg_rdata = 32'ha1b2c3d4;
        repeat (3) @(posedge clk);
        check(32'({lnk.grant_in, lnk.addr_gl_oe, lnk.data_gl_oe}), 32'h0);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        cpu_cycle(32'h5800_0010, 1'b0, 2'b00, 32'h11223344);
        check(32'({acked, wr_seen, cap_meta}), 32'({2'b11, 8'h04, 4'h0}));
        check(cap_data, 32'h44332211);
        check(32'(cap_data[HBA_MODE_BIT]), 32'h1);
        check(32'({cpu_status0_n, cpu_status1_n, cpu_code_or_ack_n, cpu_mio}), 32'he);
        cpu_cycle(32'h5800_0011, 1'b0, 2'b01, 32'h00aa0000);
        check(32'({wr_seen, cap_meta}), 32'({1'b1, 8'h04, 4'hd}));
        check(32'(cap_data[15:8]), 32'haa);
        cpu_cycle(32'h5800_0020, 1'b1, 2'b00, 32'h0);
        check(32'({acked, wr_seen}), 32'h2);
        check(rdv, 32'hd4c3b2a1);
        cpu_cycle(32'h5900_0010, 1'b0, 2'b00, 32'h1);
        check(32'({acked, wr_seen}), 32'h0);
        mst_cycle(1'b1, 32'h0000_1000, 4'h0, 4'b0000, 0);
        bus_grant_ack_n <= 1'b0;
        bus_request_n <= 1'b0;
        mst_cycle(1'b0, 32'h0000_2000, 4'hb, 4'b0110, 8);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            irq <= (k == 0);
            ext_irq <= (k == 1) ? 7'h7f : 7'h00;
            repeat (4) @(posedge clk);
            check(32'(cpu_ipl), (k == 0) ? 32'h1 : (k == 1) ? 32'h7 : 32'h0);
        end
        print_verdict();
    end
endmodule : host_bus_adapter_glue_bench
